// ### mcs_pkg.sv
// constants for the monitor configuration and first limit status registers
// assumes a 40 MHz system clock and the plain strobe register port of mcs_regs
package mcs_pkg;
	localparam logic [7:0] ADDR_CONFIG = 8'h40;
	localparam logic [7:0] ADDR_STATUS1 = 8'h41;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [7:0] STATUS1_RESET = 8'h00;
	localparam logic [7:0] RDATA_UNMAPPED = 8'h00;
	// configuration field positions
	localparam int CFG_GO = 0;
	localparam int CFG_LOCK = 1;
	localparam int CFG_READY = 2;
	localparam int CFG_FULL = 3;
	localparam int CFG_POWER = 4;
	localparam int CFG_SPINUP = 5;
	localparam int CFG_TIMEOUT = 6;
	localparam int CFG_SUPPLY5 = 7;
	// status field positions: voltages 0..3, temperatures 4..6, summary 7
	localparam int NUM_CHAN = 7;
	localparam int NUM_VOLT = 4;
	localparam int ST_SUMMARY = 7;
	// power-up default limits, used while monitoring is not started
	localparam logic [7:0] VOLT_LOW_DEFAULT = 8'h00;
	localparam logic [7:0] VOLT_HIGH_DEFAULT = 8'hFF;
	localparam logic [7:0] TEMP_LOW_DEFAULT = 8'h81;
	localparam logic [7:0] TEMP_HIGH_DEFAULT = 8'h7F;
	// settling time of the analog front end before ready is reported
	localparam int CLK_PERIOD_NS = 25;
	localparam int POWERUP_NS = 1000;
	localparam int POWERUP_CYC = (POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [5:0] PUP_CNT_RESET = 6'h00;
endpackage

// ### mcs_limit_cmp.sv
// window comparator for one monitored reading against its low and high limit
// assumes reading and limits share one clock domain; purely combinational
`timescale 1ns/1ps
module mcs_limit_cmp #(
	parameter bit IS_SIGNED = 1'b0
) (
	input wire logic [7:0] reading_i,
	input wire logic [7:0] low_i,
	input wire logic [7:0] high_i,
	output logic viol_o
);
	always_comb begin
		// above high is a violation, low side counts equality too
		if (IS_SIGNED) begin
			viol_o = ($signed(reading_i) > $signed(high_i)) || ($signed(reading_i) <= $signed(low_i));
		end else begin
			viol_o = (reading_i > high_i) || (reading_i <= low_i);
		end
	end
endmodule

// ### mcs_regs.sv
// Function
// - go bit uses programmed limits, drives control
// - go clear selects defaults, keeps programmed limits
// - go bit frozen once lock written
// - lock bit settable once, freezes lockable bits
// - lock holds until power cycle
// - ready bit set after power-up completes
// - full-speed bit, default zero, never locked
// - processor power flag, lockable read/write
// - spin-up bit holds outputs high whole timeout
// - lockable bit disables bus timeout
// - lockable bit selects 5 V or 3.3 V scaling
// - status bits 0-3 flag voltage limit violations
// - status bits 4-6 flag temperature violations
// - status read clears only subsided violations
// - status bit 7 ORs second status register
// - both registers reset to zero
// - violation is above high or at/below low
// - lock leaves voltage limits writable
//
// configuration and first limit status registers of the hardware monitor
// assumes readings, limits and second status come from logic on clk_sys_i
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
module mcs_regs (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic [mcs_pkg::NUM_CHAN-1:0][7:0] reading_i,
	input wire logic [mcs_pkg::NUM_CHAN-1:0][7:0] limit_low_i,
	input wire logic [mcs_pkg::NUM_CHAN-1:0][7:0] limit_high_i,
	input wire logic [7:0] status2_i,
	output logic monitor_go_o,
	output logic fans_full_force_o,
	output logic core_power_report_o,
	output logic spinup_pulse_disable_o,
	output logic bus_timeout_disable_o,
	output logic supply_5v_scale_o,
	output logic temp_limit_lock_o,
	output logic monitor_ready_o,
	output logic [mcs_pkg::NUM_CHAN-1:0] limit_flag_o,
	output logic status2_summary_o
);
	localparam int NUM_CH = mcs_pkg::NUM_CHAN;

	typedef struct packed {
		logic [7:0] cfg;
		logic [NUM_CH-1:0] lim;
		logic summary;
		logic [7:0] rdata;
		logic [5:0] pup_cnt;
	} mcs_state_t;

	mcs_state_t st;
	mcs_state_t next_st;
	logic [NUM_CH-1:0] viol;
	logic [NUM_CH-1:0][7:0] eff_low;
	logic [NUM_CH-1:0][7:0] eff_high;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_addr);
		hit = (a == ref_addr);
	endfunction

	// limits in force: programmed ones only while started
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CH; gi++) begin : g_chan
			localparam bit IS_TEMP = (gi >= mcs_pkg::NUM_VOLT);
			always_comb begin
				if (st.cfg[mcs_pkg::CFG_GO]) begin
					eff_low[gi] = limit_low_i[gi];
					eff_high[gi] = limit_high_i[gi];
				end else if (IS_TEMP) begin
					// programmed values stay in their registers outside
					eff_low[gi] = mcs_pkg::TEMP_LOW_DEFAULT;
					eff_high[gi] = mcs_pkg::TEMP_HIGH_DEFAULT;
				end else begin
					eff_low[gi] = mcs_pkg::VOLT_LOW_DEFAULT;
					eff_high[gi] = mcs_pkg::VOLT_HIGH_DEFAULT;
				end
			end
			mcs_limit_cmp #(
				.IS_SIGNED(IS_TEMP)
			) u_cmp (
				.reading_i(reading_i[gi]),
				.low_i(eff_low[gi]),
				.high_i(eff_high[gi]),
				.viol_o(viol[gi])
			);
		end
	endgenerate

	always_comb begin
		logic locked;
		logic cfg_wr;
		logic st_rd;
		locked = st.cfg[mcs_pkg::CFG_LOCK];
		cfg_wr = wr_i && hit(addr_i, mcs_pkg::ADDR_CONFIG);
		st_rd = rd_i && hit(addr_i, mcs_pkg::ADDR_STATUS1);
		next_st = st;

		// power-up sequencing; ready is hardware owned
		if (!st.cfg[mcs_pkg::CFG_READY]) begin
			if (st.pup_cnt == 6'(mcs_pkg::POWERUP_CYC - 1)) begin
				next_st.cfg[mcs_pkg::CFG_READY] = 1'b1;
			end else begin
				next_st.pup_cnt = st.pup_cnt + 6'h01;
			end
		end

		if (cfg_wr) begin
			// never locked: full speed and spin-up mode
			next_st.cfg[mcs_pkg::CFG_FULL] = wdata_i[mcs_pkg::CFG_FULL];
			next_st.cfg[mcs_pkg::CFG_SPINUP] = wdata_i[mcs_pkg::CFG_SPINUP];
			if (!locked) begin
				next_st.cfg[mcs_pkg::CFG_GO] = wdata_i[mcs_pkg::CFG_GO];
				next_st.cfg[mcs_pkg::CFG_POWER] = wdata_i[mcs_pkg::CFG_POWER];
				next_st.cfg[mcs_pkg::CFG_TIMEOUT] = wdata_i[mcs_pkg::CFG_TIMEOUT];
				next_st.cfg[mcs_pkg::CFG_SUPPLY5] = wdata_i[mcs_pkg::CFG_SUPPLY5];
				// a zero leaves lock open, a one closes it for good
				next_st.cfg[mcs_pkg::CFG_LOCK] = wdata_i[mcs_pkg::CFG_LOCK];
			end
			// ready bit is not taken from the write
			next_st.cfg[mcs_pkg::CFG_READY] = next_st.cfg[mcs_pkg::CFG_READY];
		end
		// status register 1 has no write path at all

		// a fresh violation in the reading cycle keeps its bit
		next_st.lim = (st.lim & ~(st_rd ? ~viol : '0)) | viol;
		next_st.summary = |status2_i;

		if (rd_i) begin
			if (hit(addr_i, mcs_pkg::ADDR_CONFIG)) begin
				next_st.rdata = st.cfg;
			end else if (st_rd) begin
				next_st.rdata = {st.summary, st.lim};
			end else begin
				next_st.rdata = mcs_pkg::RDATA_UNMAPPED;
			end
		end else begin
			next_st.rdata = mcs_pkg::RDATA_UNMAPPED;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st.cfg <= mcs_pkg::CONFIG_RESET;
			st.lim <= mcs_pkg::STATUS1_RESET[NUM_CH-1:0];
			st.summary <= mcs_pkg::STATUS1_RESET[mcs_pkg::ST_SUMMARY];
			st.rdata <= mcs_pkg::RDATA_UNMAPPED;
			st.pup_cnt <= mcs_pkg::PUP_CNT_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign rdata_o = st.rdata;
	assign monitor_go_o = st.cfg[mcs_pkg::CFG_GO];
	assign fans_full_force_o = st.cfg[mcs_pkg::CFG_FULL];
	assign core_power_report_o = st.cfg[mcs_pkg::CFG_POWER];
	assign spinup_pulse_disable_o = st.cfg[mcs_pkg::CFG_SPINUP];
	assign bus_timeout_disable_o = st.cfg[mcs_pkg::CFG_TIMEOUT];
	assign supply_5v_scale_o = st.cfg[mcs_pkg::CFG_SUPPLY5];
	// lock reaches temperature limit registers only, voltage limits stay open
	assign temp_limit_lock_o = st.cfg[mcs_pkg::CFG_LOCK];
	assign monitor_ready_o = st.cfg[mcs_pkg::CFG_READY];
	assign limit_flag_o = st.lim;
	assign status2_summary_o = st.summary;

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);

	a_lock_stays_set:
	assert property (st.cfg[mcs_pkg::CFG_LOCK] |=> st.cfg[mcs_pkg::CFG_LOCK])
	else $error("lock bit dropped without power cycle");

	a_lock_first_write:
	assert property (!st.cfg[mcs_pkg::CFG_LOCK] && wr_i && addr_i == mcs_pkg::ADDR_CONFIG
		&& wdata_i[mcs_pkg::CFG_LOCK] |=> st.cfg[mcs_pkg::CFG_LOCK])
	else $error("lock write not taken");

	a_go_frozen_locked:
	assert property (st.cfg[mcs_pkg::CFG_LOCK] |=> $stable(st.cfg[mcs_pkg::CFG_GO]))
	else $error("go bit changed after lock");

	a_lockable_bits_frozen:
	assert property (st.cfg[mcs_pkg::CFG_LOCK] |=> $stable(st.cfg[7:6]) && $stable(st.cfg[mcs_pkg::CFG_POWER]))
	else $error("lockable bit changed after lock");

	a_full_force_write:
	assert property (wr_i && addr_i == mcs_pkg::ADDR_CONFIG
		|=> fans_full_force_o == $past(wdata_i[mcs_pkg::CFG_FULL]))
	else $error("full speed bit not written");

	a_ready_after_pup:
	assert property (!monitor_ready_o && st.pup_cnt == 6'(mcs_pkg::POWERUP_CYC - 1) |=> monitor_ready_o)
	else $error("ready not set after power-up time");

	a_flag_hold_active:
	assert property (viol != '0 |=> (limit_flag_o & $past(viol)) == $past(viol))
	else $error("active violation not held");

	a_flag_clear_read:
	assert property (rd_i && addr_i == mcs_pkg::ADDR_STATUS1 && viol == '0 |=> limit_flag_o == '0)
	else $error("subsided flag not cleared on read");

	a_summary_or:
	assert property (##1 status2_summary_o == (|$past(status2_i)))
	else $error("summary bit not OR of second status");

	a_read_cfg_data:
	assert property (rd_i && addr_i == mcs_pkg::ADDR_CONFIG |=> rdata_o == $past(st.cfg))
	else $error("configuration read data wrong");

	// back-to-back reads are legal, so idle zero is only owed after a quiet cycle
	a_rdata_idle_zero:
	assert property (!rd_i |=> rdata_o == 8'h00)
	else $error("read data not zero outside read answer");

	a_status_read_data:
	assert property (rd_i && addr_i == mcs_pkg::ADDR_STATUS1
		|=> rdata_o == {$past(st.summary), $past(st.lim)})
	else $error("status read data wrong");

	a_ready_not_written:
	assert property (monitor_ready_o |=> monitor_ready_o)
	else $error("ready bit dropped");

	a_spinup_write:
	assert property (wr_i && addr_i == mcs_pkg::ADDR_CONFIG
		|=> spinup_pulse_disable_o == $past(wdata_i[mcs_pkg::CFG_SPINUP]))
	else $error("spin-up bit not written");

	a_defaults_stopped:
	assert property (!st.cfg[mcs_pkg::CFG_GO] |-> eff_low[0] == mcs_pkg::VOLT_LOW_DEFAULT
		&& eff_high[0] == mcs_pkg::VOLT_HIGH_DEFAULT && eff_low[NUM_CH-1] == mcs_pkg::TEMP_LOW_DEFAULT)
	else $error("default limits not in force while stopped");

	a_programmed_started:
	assert property (st.cfg[mcs_pkg::CFG_GO] |-> eff_low == limit_low_i && eff_high == limit_high_i)
	else $error("programmed limits not in force while started");

	a_status_no_write:
	assert property (wr_i && addr_i == mcs_pkg::ADDR_STATUS1 && viol == '0 && !rd_i
		|=> limit_flag_o == $past(st.lim))
	else $error("status register changed by a write");
endmodule

// ### mcs_sense_model.sv
// measurement-side model: readings, programmed limits and second status
// assumes the bench picks which channels read out of range, and where
`timescale 1ns/1ps
module mcs_sense_model (
	input wire logic [6:0] bad_i,
	input wire logic at_low_i,
	input wire logic [7:0] st2_i,
	output logic [6:0][7:0] reading_o,
	output logic [6:0][7:0] low_o,
	output logic [6:0][7:0] high_o,
	output logic [7:0] status2_o
);
	// limits positive so signed and unsigned channels agree
	always_comb begin
		for (int i = 0; i < 7; i++) begin
			low_o[i] = 8'h10;
			high_o[i] = 8'h60;
			reading_o[i] = !bad_i[i] ? 8'h30 : (at_low_i ? 8'h10 : 8'h61);
		end
	end
	assign status2_o = st2_i;
endmodule

// ### mcs_regs_tb.sv
// self-checking bench for the configuration and first limit status registers
// assumes mcs_regs fed by the measurement model on its sensing inputs
`timescale 1ns/1ps
module mcs_regs_tb;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [7:0] addr_i = 8'h00;
	logic [7:0] wdata_i = 8'h00;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [7:0] rdata_o, status2, st2 = 8'h00;
	logic [6:0][7:0] reading, low, high;
	logic [6:0] bad = 7'h00;
	logic [6:0] flags;
	logic at_low = 1'b0;
	logic go, full, pwr, spin, tmo, s5, lock, rdy, summ;
	int errors = 0;
	int checked = 0;
	int cycles = 0;
	always #12.5 clk_sys_i = ~clk_sys_i;
	mcs_sense_model mcs_sense_model_inst (.bad_i(bad), .at_low_i(at_low), .st2_i(st2), .reading_o(reading),
		.low_o(low), .high_o(high), .status2_o(status2));
	mcs_regs mcs_regs_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .reading_i(reading), .limit_low_i(low),
		.limit_high_i(high), .status2_i(status2), .monitor_go_o(go), .fans_full_force_o(full),
		.core_power_report_o(pwr), .spinup_pulse_disable_o(spin), .bus_timeout_disable_o(tmo),
		.supply_5v_scale_o(s5), .temp_limit_lock_o(lock), .monitor_ready_o(rdy),
		.limit_flag_o(flags), .status2_summary_o(summ));
	task automatic finish_test();
		if (errors == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_sys_i);
		wr_i <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_sys_i);
		rd_i <= 1'b0;
		#1;
		check("rdata", rdata_o, exp);
	endtask
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 2000) begin
			errors++;
			finish_test();
		end
	end
	initial begin
		repeat (2) @(posedge clk_sys_i);
		check("outs", {s5, tmo, spin, pwr, full, rdy, lock, go}, 8'h00);
		rst_n_i <= 1'b1;
		rd(8'h40, 8'h00);
		rd(8'h41, 8'h00);
		repeat (45) @(posedge clk_sys_i);
		rd(8'h40, 8'h04);
		wr(8'h41, 8'hFF);
		rd(8'h41, 8'h00);
		@(posedge clk_sys_i) bad <= 7'h7F;
		repeat (3) @(posedge clk_sys_i);
		rd(8'h41, 8'h00);
		wr(8'h40, 8'h01);
		repeat (2) @(posedge clk_sys_i);
		rd(8'h41, 8'h7F);
		check("flags", {1'b0, flags}, 8'h7F);
		rd(8'h41, 8'h7F);
		@(posedge clk_sys_i) bad <= 7'h70;
		rd(8'h41, 8'h7F);
		rd(8'h41, 8'h70);
		@(posedge clk_sys_i) bad <= 7'h00;
		rd(8'h41, 8'h70);
		rd(8'h41, 8'h00);
		@(posedge clk_sys_i) bad <= 7'h11;
		at_low <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		@(posedge clk_sys_i) bad <= 7'h00;
		rd(8'h41, 8'h11);
		rd(8'h41, 8'h00);
		@(posedge clk_sys_i) st2 <= 8'h20;
		repeat (2) @(posedge clk_sys_i);
		check("summary", {7'h00, summ}, 8'h01);
		rd(8'h41, 8'h80);
		@(posedge clk_sys_i) st2 <= 8'h00;
		repeat (2) @(posedge clk_sys_i);
		rd(8'h41, 8'h00);
		wr(8'h40, 8'hF9);
		rd(8'h40, 8'hFD);
		check("outs", {s5, tmo, spin, pwr, full, rdy, lock, go}, 8'hFD);
		wr(8'h40, 8'h02);
		rd(8'h40, 8'h06);
		wr(8'h40, 8'hFB);
		rd(8'h40, 8'h2E);
		wr(8'h40, 8'h00);
		rd(8'h40, 8'h06);
		check("lock", {7'h00, lock}, 8'h01);
		@(posedge clk_sys_i) rst_n_i <= 1'b0;
		@(posedge clk_sys_i) rst_n_i <= 1'b1;
		rd(8'h40, 8'h00);
		wr(8'h40, 8'h05);
		rd(8'h40, 8'h01);
		rd(8'h55, 8'h00);
		finish_test();
	end
endmodule
